// [logic/tpc_panel.sv]
// Operator panel control: keys, lamps, display and density mode
`timescale 1ns/100ps

module tpc_panel #(
	parameter int unsigned DEBOUNCE_N = tpc_pkg::DEBOUNCE_CYC,
	parameter int unsigned BLINK_N    = tpc_pkg::BLINK_CYC
) (
	input  wire logic                     clock,
	input  wire logic                     resetn,
	input  wire logic [tpc_pkg::NKEY-1:0] panel_keys,
	input  wire tpc_pkg::tpc_drive_t      drive,
	input  wire logic [3:0]               host_addr,
	input  wire logic                     host_wants_gcr,
	input  wire logic                     diag_done,
	input  wire logic [tpc_pkg::AW-1:0]   reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output tpc_pkg::tpc_lamps_t           lamps,
	output tpc_pkg::tpc_disp_t            disp,
	output tpc_pkg::tpc_cmd_t             cmd,
	output logic                          write_inhibit,
	output logic                          write_gcr,
	output logic [31:0]                   reg_rdata
);
	import tpc_pkg::*;

	// Hex digit to display character
	function automatic logic [7:0] hex_char(input logic [3:0] v);
		hex_char = (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
	endfunction : hex_char

	// ****************************************
	// Declarations
	// ****************************************
	logic [NKEY-1:0]  key_s1_r;                // First sync stage
	logic [NKEY-1:0]  key_s2_r;                // Second sync stage
	logic [NKEY-1:0]  key_db_r;                // Debounced level
	logic [NKEY-1:0]  key_prev_r;              // Debounced level, delayed
	logic [31:0]      db_cnt_r [NKEY];         // Settle counters
	logic [NKEY-1:0]  press;                   // One pulse per press
	logic [31:0]      blink_cnt_r;             // Flash timer
	logic             blink_r;                 // Flash phase
	tpc_state_t       state_r;                 // Panel state
	tpc_dens_t        dens_r;                  // Density mode
	logic             start_done_r;            // Power-up diag launched
	logic             mc_r;                    // Machine check present
	logic [11:0]      fault_r;                 // Posted fault code
	logic             eot_hold_r;              // End marker seen
	logic             unload_blk_r;            // Ready held off by unload
	logic             loaded_prev_r;           // Tape loaded, delayed
	logic [3:0]       drv_addr_r;              // Configured drive address
	logic [1:0]       dreq_r;                  // Diagnostic display request
	logic [7:0]       test_r;                  // Test or data number
	logic             online;                  // Online status
	logic             tape_keys_ok;            // Tape keys accepted
	logic             fault_evt;               // Fault from drive
	logic             wr_fault;                // Fault posted by software
	logic             wr_diag;                 // Diagnostic register write
	logic             dens_wr;                 // Diagnostic density write
	tpc_disp_t        disp_nxt;                // Next display content
	tpc_dens_t        dens_sel;                // Density from register

	assign online       = (state_r == ST_ONLINE);
	assign tape_keys_ok = (state_r == ST_OFFLINE);
	assign fault_evt    = drive.load_check | drive.drive_fault;
	assign wr_fault     = reg_wr & (reg_addr == REG_FAULT_OFS);
	assign wr_diag      = reg_wr & (reg_addr == REG_DIAG_OFS);
	assign dens_wr      = wr_diag & reg_wdata[DIAG_DEN_BIT];

	// Register field to density mode
	always_comb begin
		unique case (reg_wdata[DIAG_DSEL_LSB +: 2])
			2'h1:    dens_sel = DN_1600;
			2'h2:    dens_sel = DN_6250;
			default: dens_sel = DN_HOST;
		endcase
	end

	// ****************************************
	// Keys
	// ****************************************
	// Two-stage synchroniser for panel keys
	always_ff @(posedge clock) begin
		if (!resetn) begin
			key_s1_r <= '0;
			key_s2_r <= '0;
		end else begin
			key_s1_r <= panel_keys;
			key_s2_r <= key_s1_r;
		end
	end

	// Debounce: level changes only after it stays put
	always_ff @(posedge clock) begin
		if (!resetn) begin
			key_db_r   <= '0;
			key_prev_r <= '0;
			for (int i = 0; i < NKEY; i++) begin
				db_cnt_r[i] <= '0;
			end
		end else begin
			key_prev_r <= key_db_r;
			for (int i = 0; i < NKEY; i++) begin
				if (key_s2_r[i] == key_db_r[i]) begin
					db_cnt_r[i] <= '0;
				end else if (db_cnt_r[i] >= DEBOUNCE_N - 1) begin
					db_cnt_r[i] <= '0;
					key_db_r[i] <= key_s2_r[i];
				end else begin
					db_cnt_r[i] <= db_cnt_r[i] + 32'h1;
				end
			end
		end
	end

	// Act on the press edge only
	assign press = key_db_r & ~key_prev_r;

	// ****************************************
	// Flash timer
	// ****************************************
	// Toggles the flash phase every half period
	always_ff @(posedge clock) begin
		if (!resetn) begin
			blink_cnt_r <= '0;
			blink_r     <= 1'b0;
		end else if (blink_cnt_r >= BLINK_N - 1) begin
			blink_cnt_r <= '0;
			blink_r     <= ~blink_r;
		end else begin
			blink_cnt_r <= blink_cnt_r + 32'h1;
		end
	end

	// ****************************************
	// Panel state
	// ****************************************
	// Power-up, offline and online status
	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_r <= ST_POWERUP;
		end else if (press[KEY_RST]) begin
			state_r <= ST_OFFLINE;
		end else if (press[KEY_ONL]) begin
			state_r <= ST_ONLINE;
		end else begin
			unique case (state_r)
				ST_POWERUP: begin
					if (diag_done) begin
						state_r <= ST_OFFLINE;
					end
				end
				ST_OFFLINE: state_r <= ST_OFFLINE;
				ST_ONLINE:  state_r <= ST_ONLINE;
			endcase
		end
	end

	// ****************************************
	// Commands to the sequencer
	// ****************************************
	// One-cycle command pulses
	always_ff @(posedge clock) begin
		if (!resetn) begin
			cmd          <= '0;
			start_done_r <= 1'b0;
		end else begin
			cmd.diag_start <= !start_done_r;
			start_done_r   <= 1'b1;
			cmd.load   <= press[KEY_LDRW] & tape_keys_ok & !drive.tape_loaded;
			cmd.rewind <= press[KEY_LDRW] & tape_keys_ok & drive.tape_loaded;
			cmd.unload <= press[KEY_RWUL] & tape_keys_ok;
			cmd.abort  <= press[KEY_RST] | (press[KEY_ONL] & !online);
			cmd.diag_stop <= press[KEY_RST] | (press[KEY_ONL] & !online);
		end
	end

	// ****************************************
	// Density mode
	// ****************************************
	// Density key, tape load and diagnostics
	always_ff @(posedge clock) begin
		if (!resetn) begin
			dens_r        <= DN_HOST;
			loaded_prev_r <= 1'b0;
		end else begin
			loaded_prev_r <= drive.tape_loaded;
			if (dens_wr) begin
				dens_r <= dens_sel;
			end else if (drive.tape_loaded && !loaded_prev_r) begin
				dens_r <= DN_HOST;
			end else if (press[KEY_DENS] && (!drive.tape_loaded || drive.at_bot)) begin
				unique case (dens_r)
					DN_HOST: dens_r <= DN_1600;
					DN_1600: dens_r <= DN_6250;
					DN_6250: dens_r <= DN_HOST;
				endcase
			end
		end
	end

	// ****************************************
	// Fault and marker status
	// ****************************************
	// Machine check: a new fault wins over a clear
	always_ff @(posedge clock) begin
		if (!resetn) begin
			mc_r    <= 1'b0;
			fault_r <= FAULT_RST;
		end else if (fault_evt) begin
			mc_r    <= 1'b1;
			fault_r <= drive.fault_code;
		end else if (wr_fault) begin
			mc_r    <= 1'b1;
			fault_r <= reg_wdata[11:0];
		end else if (press[KEY_RST]) begin
			mc_r <= 1'b0;
		end
	end

	// End marker holds until moved back past sensor
	always_ff @(posedge clock) begin
		if (!resetn) begin
			eot_hold_r <= 1'b0;
		end else if (drive.eot_sensor) begin
			eot_hold_r <= 1'b1;
		end else if (drive.rewinding || drive.reverse_motion) begin
			eot_hold_r <= 1'b0;
		end
	end

	// Ready stays off once unload is ordered
	always_ff @(posedge clock) begin
		if (!resetn) begin
			unload_blk_r <= 1'b0;
		end else if (cmd.unload) begin
			unload_blk_r <= 1'b1;
		end else if (!drive.tape_loaded) begin
			unload_blk_r <= 1'b0;
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	// Drive address and diagnostic display request
	always_ff @(posedge clock) begin
		if (!resetn) begin
			drv_addr_r <= ADDR_RST;
			dreq_r     <= DREQ_IDLE;
			test_r     <= TEST_RST;
		end else begin
			if (reg_wr && reg_addr == REG_ADDR_OFS) begin
				drv_addr_r <= reg_wdata[3:0];
			end
			if (press[KEY_RST] || press[KEY_ONL]) begin
				dreq_r <= DREQ_IDLE;
			end else if (wr_diag) begin
				dreq_r <= reg_wdata[1:0];
				test_r <= reg_wdata[DIAG_TEST_LSB +: 8];
			end
		end
	end

	// Read data stands the cycle after the strobe only
	always_ff @(posedge clock) begin
		if (!resetn) begin
			reg_rdata <= '0;
		end else if (!reg_rd) begin
			reg_rdata <= '0;
		end else begin
			unique case (reg_addr)
				REG_ADDR_OFS:  reg_rdata <= {28'h0, drv_addr_r};
				REG_FAULT_OFS: reg_rdata <= {19'h0, mc_r, fault_r};
				REG_DIAG_OFS:  reg_rdata <= {16'h0, test_r, 6'h0, dreq_r};
				REG_STAT_OFS:  reg_rdata <= {17'h0, state_r, dens_r, lamps};
				default:       reg_rdata <= '0;
			endcase
		end
	end

	// ****************************************
	// Lamps and write control
	// ****************************************
	// All lamps come from flip-flops
	always_ff @(posedge clock) begin
		if (!resetn) begin
			lamps         <= '0;
			write_inhibit <= 1'b0;
			write_gcr     <= 1'b0;
		end else begin
			lamps.ready  <= drive.tape_loaded & !drive.rewinding & !unload_blk_r;
			lamps.select <= online & (host_addr == drv_addr_r);
			lamps.marker <= drive.at_bot | eot_hold_r;
			lamps.online <= online;
			lamps.machine_fault_lamp <= mc_r & blink_r;
			lamps.write_protect_lamp <= drive.tape_loaded & !drive.write_ring;
			write_inhibit <= drive.tape_loaded & !drive.write_ring;
			if (drive.dens_valid) begin
				lamps.host_density_choice <= 1'b0;
				lamps.d1600 <= !drive.dens_gcr;
				lamps.d6250 <= drive.dens_gcr;
			end else begin
				lamps.host_density_choice <= (dens_r == DN_HOST);
				lamps.d1600 <= (dens_r != DN_6250);
				lamps.d6250 <= (dens_r == DN_6250);
			end
			unique case (dens_r)
				DN_HOST: write_gcr <= host_wants_gcr;
				DN_1600: write_gcr <= 1'b0;
				DN_6250: write_gcr <= 1'b1;
			endcase
		end
	end

	// ****************************************
	// Display
	// ****************************************
	// Display content by priority
	always_comb begin
		disp_nxt.all_segs = |key_db_r;
		if (online) begin
			disp_nxt.ch = {4{CH_BLANK}};
		end else if (mc_r) begin
			disp_nxt.ch = {CH_BLANK, hex_char(fault_r[11:8]),
				hex_char(fault_r[7:4]), hex_char(fault_r[3:0])};
		end else if (state_r == ST_POWERUP) begin
			disp_nxt.ch = {CH_AT, 8'h30, 8'h30, CH_BLANK};
		end else begin
			unique case (dreq_r)
				DREQ_TEST: disp_nxt.ch = {CH_AT, hex_char(test_r[7:4]),
					hex_char(test_r[3:0]), CH_BLANK};
				DREQ_DATA: disp_nxt.ch = {CH_BLANK, CH_BLANK, CH_QUES, CH_QUES};
				DREQ_ADDR: disp_nxt.ch = {4{CH_QUES}};
				default:   disp_nxt.ch = {4{CH_DASH}};
			endcase
		end
	end

	// Registered display
	always_ff @(posedge clock) begin
		if (!resetn) begin
			disp <= '0;
		end else begin
			disp <= disp_nxt;
		end
	end

endmodule : tpc_panel

// [logic/tpc_pkg.sv]
// Shared constants, types and carriers of the tape operator panel control
package tpc_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ       = 125_000_000;            // System clock rate
	localparam int DEBOUNCE_MS  = 10;                     // Key settle time
	localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int BLINK_MS     = 250;                    // Half period of lamp flash
	localparam int BLINK_CYC    = CLK_HZ / 1000 * BLINK_MS;

	// ****************************************
	// Keys
	// ****************************************
	localparam int NKEY     = 5;
	localparam int KEY_DENS = 0;                          // Density select
	localparam int KEY_RWUL = 1;                          // Rewind and unload
	localparam int KEY_RST  = 2;                          // Subsystem reset
	localparam int KEY_LDRW = 3;                          // Load or rewind
	localparam int KEY_ONL  = 4;                          // Go online

	// ****************************************
	// Register map
	// ****************************************
	localparam int         AW            = 8;
	localparam logic [7:0] REG_ADDR_OFS  = 8'h00;         // Drive address
	localparam logic [7:0] REG_FAULT_OFS = 8'h04;         // Fault code post
	localparam logic [7:0] REG_DIAG_OFS  = 8'h08;         // Diagnostic display and density
	localparam logic [7:0] REG_STAT_OFS  = 8'h0c;         // Panel status, read only
	localparam logic [3:0] ADDR_RST      = 4'h0;
	localparam logic [11:0] FAULT_RST    = 12'h000;
	localparam logic [7:0] TEST_RST      = 8'h00;
	localparam int         FAULT_MC_BIT  = 12;
	localparam int         DIAG_TEST_LSB = 8;
	localparam int         DIAG_DEN_BIT  = 16;
	localparam int         DIAG_DSEL_LSB = 17;

	// Display requests from diagnostic firmware
	localparam logic [1:0] DREQ_IDLE = 2'h0;
	localparam logic [1:0] DREQ_TEST = 2'h1;
	localparam logic [1:0] DREQ_DATA = 2'h2;
	localparam logic [1:0] DREQ_ADDR = 2'h3;

	// Character codes
	localparam logic [7:0] CH_BLANK = 8'h20;
	localparam logic [7:0] CH_DASH  = 8'h2d;
	localparam logic [7:0] CH_QUES  = 8'h3f;
	localparam logic [7:0] CH_AT    = 8'h40;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		ST_POWERUP = 3'b001,
		ST_OFFLINE = 3'b010,
		ST_ONLINE  = 3'b100
	} tpc_state_t;

	typedef enum logic [2:0] {
		DN_HOST = 3'b001,
		DN_1600 = 3'b010,
		DN_6250 = 3'b100
	} tpc_dens_t;

	typedef struct packed {
		logic        tape_loaded;
		logic        at_bot;
		logic        eot_sensor;
		logic        rewinding;
		logic        reverse_motion;
		logic        write_ring;
		logic        dens_valid;
		logic        dens_gcr;
		logic        load_check;
		logic        drive_fault;
		logic [11:0] fault_code;
	} tpc_drive_t;

	typedef struct packed {
		logic ready;
		logic select;
		logic marker;
		logic online;
		logic machine_fault_lamp;
		logic write_protect_lamp;
		logic host_density_choice;
		logic d1600;
		logic d6250;
	} tpc_lamps_t;

	typedef struct packed {
		logic [3:0][7:0] ch;
		logic            all_segs;
	} tpc_disp_t;

	typedef struct packed {
		logic load;
		logic rewind;
		logic unload;
		logic abort;
		logic diag_start;
		logic diag_stop;
	} tpc_cmd_t;

endpackage : tpc_pkg

// [bench/tpc_panel_checker.sv]
// Concurrent checks on the operator panel control ports
`timescale 1ns/100ps
module tpc_panel_checker (
	input wire logic                clock,
	input wire logic                resetn,
	input wire tpc_pkg::tpc_drive_t drive,
	input wire tpc_pkg::tpc_lamps_t lamps,
	input wire tpc_pkg::tpc_disp_t  disp,
	input wire tpc_pkg::tpc_cmd_t   cmd,
	input wire logic                write_inhibit
);
	import tpc_pkg::*;
	// ****************************************
	// Clocking and helpers
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	logic tape_cmd;                                       // Any tape motion request
	assign tape_cmd = cmd.load | cmd.rewind | cmd.unload;
	// ****************************************
	// Assertions
	// ****************************************
	chk_online_blank: assert property (lamps.online |-> disp.ch == {4{CH_BLANK}})
		else $error("Display not blank while online");
	chk_fault_shown: assert property (lamps.machine_fault_lamp && !lamps.online |-> disp.ch[3] == CH_BLANK)
		else $error("Fault lamp without fault display");
	chk_ready_cause: assert property (lamps.ready |-> $past(drive.tape_loaded) && !$past(drive.rewinding))
		else $error("Ready lamp without loaded idle tape");
	chk_select_online: assert property (lamps.select |-> lamps.online)
		else $error("Select lamp while offline");
	chk_marker_bot: assert property ($past(resetn) && $past(drive.at_bot) |-> lamps.marker)
		else $error("Marker lamp dark at start marker");
	chk_protect_cause: assert property (write_inhibit |-> lamps.write_protect_lamp && !$past(drive.write_ring))
		else $error("Write inhibit without protect lamp");
	chk_density_code: assert property (!(lamps.host_density_choice && !lamps.d1600)
		&& !(lamps.d6250 && (lamps.d1600 || lamps.host_density_choice)))
		else $error("Illegal density lamp combination");
	chk_unload_ready: assert property (cmd.unload |-> ##[1:2] !lamps.ready)
		else $error("Ready lamp stays on after unload");
	chk_tape_keys: assert property (lamps.online |-> !tape_cmd)
		else $error("Tape command while online");
	chk_stop_settles: assert property (cmd.diag_stop |=> lamps.online || disp.ch == {4{CH_DASH}})
		else $error("Panel neither online nor idle after stop");
	chk_cmd_once: assert property (tape_cmd |=> !tape_cmd [*3])
		else $error("Tape command repeats");
	// Main scenarios seen
	cov_online: cover property (lamps.online && lamps.select);
	cov_load: cover property (cmd.load);
	cov_fault: cover property (lamps.machine_fault_lamp);
	cov_segs: cover property (disp.all_segs);
endmodule : tpc_panel_checker

bind tpc_panel tpc_panel_checker u_chk (.clock(clock), .resetn(resetn), .drive(drive), .lamps(lamps),
	.disp(disp), .cmd(cmd), .write_inhibit(write_inhibit));

// [bench/tpc_drive_model.sv]
// Behavioural model of the drive status logic beside the panel
`timescale 1ns/100ps
module tpc_drive_model (
	input  wire logic              clock,
	input  wire logic              resetn,
	input  wire tpc_pkg::tpc_cmd_t cmd,
	input  wire logic              ring,
	input  wire logic              end_of_tape_marker,
	input  wire logic              leave_bot,
	input  wire logic              dvalid,
	input  wire logic              dgcr,
	output tpc_pkg::tpc_drive_t    drive
);
	import tpc_pkg::*;
	logic [4:0] busy_r;                                   // Cycles left of a motion
	logic       drop_r;                                   // Motion ends unloaded
	logic       loaded_r;                                 // Tape in path
	logic       bot_r;                                    // At start marker
	logic       tape_go;                                  // Motion request
	assign tape_go = cmd.load | cmd.rewind | cmd.unload;
	// Motion takes 20 cycles, slow enough to be seen mid-way
	always_ff @(posedge clock) begin
		if (!resetn) begin
			busy_r   <= 5'h00;
			drop_r   <= 1'b0;
			loaded_r <= 1'b0;
			bot_r    <= 1'b0;
		end else if (tape_go) begin
			busy_r <= 5'h14;
			drop_r <= cmd.unload;
			bot_r  <= 1'b0;
		end else if (busy_r == 5'h01) begin
			busy_r   <= 5'h00;
			loaded_r <= !drop_r;
			bot_r    <= !drop_r;
		end else if (busy_r != 5'h00) begin
			busy_r <= busy_r - 5'h01;
		end else if (leave_bot) begin
			bot_r <= 1'b0;
		end
	end
	// Status levels; loading is not a rewind
	always_comb begin
		drive             = '0;
		drive.tape_loaded = loaded_r;
		drive.at_bot      = bot_r;
		drive.eot_sensor  = end_of_tape_marker;
		drive.rewinding   = (busy_r != 5'h00) && loaded_r;
		drive.write_ring  = ring;
		drive.dens_valid  = dvalid;
		drive.dens_gcr    = dgcr;
	end
endmodule : tpc_drive_model

// [bench/tpc_panel_tb.sv]
// Self-checking testbench of the operator panel control
`timescale 1ns/100ps
module tpc_panel_tb;
	import tpc_pkg::*;
	logic            clock;
	logic            resetn;
	logic [NKEY-1:0] panel_keys;
	tpc_drive_t      drive;
	logic [3:0]      host_addr;
	logic            gcr_wish;
	logic            diag_done;
	logic [AW-1:0]   reg_addr;
	logic [31:0]     reg_wdata;
	logic            reg_wr;
	logic            reg_rd;
	tpc_lamps_t      lamps;
	tpc_disp_t       disp;
	tpc_cmd_t        cmd;
	logic            write_inhibit;
	logic            write_gcr;
	logic [31:0]     reg_rdata;
	logic            ring, end_of_tape_marker, leave_bot, dvalid, dgcr;
	int              n_errors = 0;
	int              n_compared = 0;
	logic            flash_seen;
	// Density lamps after each press: write_gcr, host, 1600, 6250
	localparam logic [3:0] DENS_SEQ [3] = '{4'h2, 4'h9, 4'h6};
	// Prompts: test 42, data, address
	localparam logic [31:0] PROMPT [3] = '{32'h40343220, 32'h20203f3f, 32'h3f3f3f3f};
	// ****************************************
	// Instances
	// ****************************************
	tpc_panel #(.DEBOUNCE_N(4), .BLINK_N(8)) dut (.clock(clock), .resetn(resetn), .panel_keys(panel_keys),
		.drive(drive), .host_addr(host_addr), .host_wants_gcr(gcr_wish), .diag_done(diag_done),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .lamps(lamps),
		.disp(disp), .cmd(cmd), .write_inhibit(write_inhibit), .write_gcr(write_gcr), .reg_rdata(reg_rdata));
	tpc_drive_model u_drive (.clock(clock), .resetn(resetn), .cmd(cmd), .ring(ring), .end_of_tape_marker(end_of_tape_marker),
		.leave_bot(leave_bot), .dvalid(dvalid), .dgcr(dgcr), .drive(drive));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic compare(string what, logic [31:0] seen, logic [31:0] exp_val);
		n_compared++;
		if (seen !== exp_val) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp_val, seen);
		end
	endtask : compare
	task automatic cyc(int n);
		repeat (n) @(posedge clock);
	endtask : cyc
	task automatic reg_write(logic [7:0] a, logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		cyc(1);
		reg_wr <= 1'b0;
		cyc(2);
	endtask : reg_write
	// Read data stands only in the cycle after the strobe; realign to the edge after
	task automatic reg_read(logic [7:0] a, logic [31:0] exp_val);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		cyc(1);
		reg_rd <= 1'b0;
		#1 compare("rdata", reg_rdata, exp_val);
		cyc(1);
	endtask : reg_read
	// Key held past sync and debounce, then released
	task automatic key_down(int k);
		panel_keys[k] <= 1'b1;
		cyc(12);
	endtask : key_down
	task automatic key_up(int k);
		panel_keys[k] <= 1'b0;
		cyc(30);
	endtask : key_up
	task automatic press(int k);
		key_down(k);
		key_up(k);
	endtask : press
	task automatic print_verdict();
		$display("Compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	// ****************************************
	// Clock and watchdog
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		cyc(5000);
		n_errors++;
		print_verdict();
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		{panel_keys, host_addr, gcr_wish, diag_done, reg_addr, reg_wdata, reg_wr, reg_rd} <= '0;
		{ring, end_of_tape_marker, leave_bot, dvalid, dgcr, resetn} <= 6'h20;
		cyc(2);
		resetn <= 1'b1;
		cyc(3);
		compare("disp", disp.ch, 32'h40303020);
		compare("dens", {lamps.host_density_choice, lamps.d1600, lamps.d6250}, 3'h6);
		reg_read(REG_ADDR_OFS, 32'h0);
		reg_read(8'h10, 32'h0);
		diag_done <= 1'b1;
		cyc(3);
		compare("disp", disp.ch, 32'h2d2d2d2d);
		for (int i = 0; i < 3; i++) begin
			press(KEY_DENS);
			compare("dens", {write_gcr, lamps.host_density_choice, lamps.d1600, lamps.d6250}, DENS_SEQ[i]);
		end
		press(KEY_DENS);
		press(KEY_LDRW);
		compare("loaded", {lamps.ready, lamps.marker, lamps.write_protect_lamp}, 3'h6);
		compare("dens", {lamps.host_density_choice, lamps.d1600, lamps.d6250}, 3'h6);
		ring      <= 1'b0;
		leave_bot <= 1'b1;
		cyc(1);
		leave_bot <= 1'b0;
		cyc(4);
		compare("protect", {lamps.write_protect_lamp, write_inhibit}, 2'h3);
		press(KEY_DENS);
		compare("dens", {lamps.host_density_choice, lamps.d1600, lamps.d6250}, 3'h6);
		end_of_tape_marker <= 1'b1;
		cyc(3);
		end_of_tape_marker <= 1'b0;
		cyc(4);
		compare("marker", lamps.marker, 1'b1);
		{dvalid, dgcr} <= 2'h3;
		cyc(4);
		compare("dens", {lamps.host_density_choice, lamps.d1600, lamps.d6250}, 3'h1);
		dvalid <= 1'b0;
		key_down(KEY_LDRW);
		compare("rewind", {lamps.ready, lamps.marker}, 2'h0);
		key_up(KEY_LDRW);
		compare("rewound", {lamps.ready, lamps.marker}, 2'h3);
		reg_write(REG_FAULT_OFS, 32'h123);
		compare("disp", disp.ch, 32'h20313233);
		reg_read(REG_FAULT_OFS, 32'h1123);
		flash_seen = lamps.machine_fault_lamp;
		cyc(8);
		compare("flash", flash_seen ^ lamps.machine_fault_lamp, 1'b1);
		key_down(KEY_RST);
		compare("segs", disp.all_segs, 1'b1);
		key_up(KEY_RST);
		compare("segs", disp.all_segs, 1'b0);
		compare("idle", disp.ch, 32'h2d2d2d2d);
		reg_read(REG_FAULT_OFS, 32'h123);
		for (int i = 0; i < 3; i++) begin
			reg_write(REG_DIAG_OFS, 32'h4200 + i + 1);
			compare("prompt", disp.ch, PROMPT[i]);
		end
		reg_write(REG_DIAG_OFS, 32'h0);
		reg_write(REG_ADDR_OFS, 32'h5);
		reg_read(REG_ADDR_OFS, 32'h5);
		host_addr <= 4'h5;
		press(KEY_ONL);
		compare("online", {lamps.online, lamps.select}, 2'h3);
		compare("blank", disp.ch, {4{CH_BLANK}});
		host_addr <= 4'h6;
		key_down(KEY_LDRW);
		compare("online", {lamps.online, lamps.select, lamps.ready}, 3'h5);
		key_up(KEY_LDRW);
		press(KEY_RST);
		compare("offline", lamps.online, 1'b0);
		compare("idle", disp.ch, 32'h2d2d2d2d);
		press(KEY_RWUL);
		compare("unload", {lamps.ready, lamps.write_protect_lamp}, 2'h0);
		print_verdict();
	end
endmodule : tpc_panel_tb
